// ==== hdl/eedm_regs.svh ====
/*
 * Constants for the data EEPROM controller: addresses, control register
 * layout, unlock codes and timing counts.
 * Assumes inclusion by bare name from files under hdl/.
 */
`ifndef EEDM_REGS_SVH
`define EEDM_REGS_SVH
// ---------------------------------------------
// Address map
// ---------------------------------------------
`define EEDM_ADDR_W 11
`define EEDM_SPACE_LAST 11'h3ff
`define EEDM_PAGE_HI 10
`define EEDM_PAGE_LO 7
`define EEDM_COL_HI 6
`define EEDM_COL_LO 0
`define EEDM_PAGE_BYTES 128
// ---------------------------------------------
// Control register layout
// ---------------------------------------------
`define EEDM_CTRL_ENABLE_BIT 1
`define EEDM_CTRL_BUSY_BIT 0
`define EEDM_UNLOCK_FIRST 8'h52
`define EEDM_UNLOCK_SECOND 8'ha2
`define EEDM_AUX_STRETCH_BIT 0
// ---------------------------------------------
// Timing
// ---------------------------------------------
`define EEDM_CLK_MHZ 25
`define EEDM_PROG_TIME_US 10
`define EEDM_PROG_CYCLES (`EEDM_PROG_TIME_US * `EEDM_CLK_MHZ)
`endif

// ==== hdl/eedm_pkg.sv ====
/*
 * Types shared by both ends of the data EEPROM link.
 * Assumes eedm_regs.svh is on the include path.
 */
package eedm_pkg;
   typedef logic [7:0] eedm_byte_t;
   typedef logic [10:0] eedm_addr_t;
   // Register selected by a special-function access
   typedef enum logic [1:0] {
      EEDM_SFR_CTRL = 2'h1,
      EEDM_SFR_AUX = 2'h2
   } eedm_sfr_e;
endpackage

// ==== hdl/eedm_if.sv ====
/*
 * Link between the core-side requester and the data EEPROM controller.
 * Assumes one clock shared by both ends; the bench joins them.
 */
`timescale 1ns/100ps
interface eedm_if;
   logic xdata_req;
   logic xdata_we;
   eedm_pkg::eedm_addr_t xdata_addr;
   eedm_pkg::eedm_byte_t xdata_wdata;
   logic sfr_req;
   logic sfr_we;
   eedm_pkg::eedm_sfr_e sfr_sel;
   eedm_pkg::eedm_byte_t sfr_wdata;
   logic rsp_valid;
   eedm_pkg::eedm_byte_t rsp_rdata;
   logic ram_select;
   modport ctrl (input xdata_req, xdata_we, xdata_addr, xdata_wdata, sfr_req, sfr_we,
      sfr_sel, sfr_wdata, output rsp_valid, rsp_rdata, ram_select);
   modport core (output xdata_req, xdata_we, xdata_addr, xdata_wdata, sfr_req, sfr_we,
      sfr_sel, sfr_wdata, input rsp_valid, rsp_rdata, ram_select);
endinterface

// ==== hdl/eedm_ctrl.sv ====
/*
 * Data EEPROM controller: column latches with written flags, unlock
 * sequence, row programming timer, 1-Kbyte array in flip-flops.
 * Assumes one requester on the link, one request in flight at a time.
 */
`timescale 1ns/100ps
`include "eedm_regs.svh"
module eedm_ctrl #(
   parameter int PROG_CYCLES = `EEDM_PROG_CYCLES
) (
   input wire logic ref_clk,
   input wire logic reset_n,
   eedm_if.ctrl link
);
   // ---------------------------------------------
   // Sizes
   // ---------------------------------------------
   localparam int DEPTH = `EEDM_SPACE_LAST + 1;
   localparam int PAGES = DEPTH / `EEDM_PAGE_BYTES;
   localparam int PW = `EEDM_PAGE_HI - `EEDM_PAGE_LO + 1;
   localparam int BW = `EEDM_COL_HI - `EEDM_COL_LO + 1;
   localparam int CW = $clog2(PROG_CYCLES + 1);

   // ---------------------------------------------
   // Elaboration checks
   // ---------------------------------------------
   if (PROG_CYCLES < 1) begin
      $error("PROG_CYCLES must be at least one");
   end
   if (`EEDM_PAGE_BYTES != 2 ** BW) begin
      $error("Page size must match the byte-select field");
   end
   if (DEPTH % `EEDM_PAGE_BYTES != 0) begin
      $error("EEPROM space must hold whole pages");
   end
   if (PAGES > 2 ** PW) begin
      $error("Page count exceeds the page-select field");
   end

   // ---------------------------------------------
   // State
   // ---------------------------------------------
   typedef enum logic [2:0] {
      EEDM_IDLE = 3'b001,
      EEDM_ARMED = 3'b010,
      EEDM_PROG = 3'b100
   } eedm_state_e;

   // The array lives in flip-flops; the timer stands in for the cell write time
   typedef struct packed {
      eedm_state_e state;
      logic eeprom_space_enable;
      logic access_stretch_bit;
      logic [DEPTH*8-1:0] array;
      logic [`EEDM_PAGE_BYTES*8-1:0] latch;
      logic [`EEDM_PAGE_BYTES-1:0] written;
      logic page_held;
      logic [PW-1:0] page;
      logic [CW-1:0] timer;
      logic rsp_valid;
      logic [7:0] rsp_rdata;
      logic ram_select;
   } eedm_ctrl_s;

   eedm_ctrl_s st_reg;
   eedm_ctrl_s st_next;

   // ---------------------------------------------
   // Decode
   // ---------------------------------------------
   logic eeprom_program_busy;
   logic in_space;
   logic [PW-1:0] req_page;
   logic [BW-1:0] req_col;
   logic latch_ok;
   logic prog_last;
   assign eeprom_program_busy = (st_reg.state == EEDM_PROG);
   assign in_space = st_reg.eeprom_space_enable
      && link.xdata_addr <= `EEDM_SPACE_LAST;
   assign req_page = link.xdata_addr[`EEDM_PAGE_HI:`EEDM_PAGE_LO];
   assign req_col = link.xdata_addr[`EEDM_COL_HI:`EEDM_COL_LO];
   // A byte off the held page is dropped rather than merged into the wrong row
   assign latch_ok = !eeprom_program_busy
      && (!st_reg.page_held || req_page == st_reg.page);
   assign prog_last = eeprom_program_busy && st_reg.timer <= CW'(1);

   always_comb begin
      st_next = st_reg;
      st_next.rsp_valid = 1'b0;
      st_next.ram_select = 1'b0;
      // ---------------------------------------------
      // Moves on the data space
      // ---------------------------------------------
      if (link.xdata_req) begin
         st_next.rsp_valid = 1'b1;
         st_next.rsp_rdata = 8'h00;
         if (!in_space) begin
            st_next.ram_select = 1'b1;
         end else if (link.xdata_we) begin
            // Latch writes during programming would corrupt the row in flight
            if (latch_ok) begin
               st_next.latch[req_col*8 +: 8] = link.xdata_wdata;
               st_next.written[req_col] = 1'b1;
               st_next.page_held = 1'b1;
               st_next.page = req_page;
            end
         end else if (!eeprom_program_busy) begin
            st_next.rsp_rdata = st_reg.array[link.xdata_addr*8 +: 8];
         end else begin
            // Segment unavailable while busy; all ones marks the refused read
            st_next.rsp_rdata = 8'hff;
         end
      end
      // ---------------------------------------------
      // Special-function registers
      // ---------------------------------------------
      if (link.sfr_req) begin
         st_next.rsp_valid = 1'b1;
         st_next.rsp_rdata = 8'h00;
         if (link.sfr_sel == eedm_pkg::EEDM_SFR_AUX) begin
            if (link.sfr_we) begin
               st_next.access_stretch_bit = link.sfr_wdata[`EEDM_AUX_STRETCH_BIT];
            end
            st_next.rsp_rdata[`EEDM_AUX_STRETCH_BIT] = st_reg.access_stretch_bit;
         end else begin
            if (link.sfr_we) begin
               st_next.eeprom_space_enable = link.sfr_wdata[`EEDM_CTRL_ENABLE_BIT];
               // Unlock pair must be back to back control writes; a value other than either unlock code disarms
               unique case (st_reg.state)
                  EEDM_IDLE: begin
                     if (link.sfr_wdata == `EEDM_UNLOCK_FIRST) begin
                        st_next.state = EEDM_ARMED;
                     end
                  end
                  EEDM_ARMED: begin
                     if (link.sfr_wdata == `EEDM_UNLOCK_SECOND) begin
                        st_next.state = EEDM_PROG;
                        st_next.timer = CW'(PROG_CYCLES);
                     end else if (link.sfr_wdata != `EEDM_UNLOCK_FIRST) begin
                        st_next.state = EEDM_IDLE;
                     end
                  end
                  EEDM_PROG: begin
                     // A row in flight ignores further unlock codes
                  end
               endcase
            end
            st_next.rsp_rdata[`EEDM_CTRL_ENABLE_BIT] = st_reg.eeprom_space_enable;
            st_next.rsp_rdata[`EEDM_CTRL_BUSY_BIT] = eeprom_program_busy;
         end
      end
      // ---------------------------------------------
      // Row programming
      // ---------------------------------------------
      if (eeprom_program_busy) begin
         if (!prog_last) begin
            // Count down the cell write time before the row is committed
            st_next.timer = st_reg.timer - CW'(1);
         end else begin
            // Only flagged bytes reach the row; the rest keep their old value
            for (int i = 0; i < `EEDM_PAGE_BYTES; i++) begin
               if (st_reg.written[i]) begin
                  st_next.array[(st_reg.page*`EEDM_PAGE_BYTES + i)*8 +: 8] =
                     st_reg.latch[i*8 +: 8];
               end
            end
            st_next.written = '0;
            st_next.page_held = 1'b0;
            st_next.timer = '0;
            st_next.state = EEDM_IDLE;
         end
      end
   end

   // ---------------------------------------------
   // State register
   // ---------------------------------------------
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         st_reg <= '0;
         st_reg.state <= EEDM_IDLE;
         // Erased cells read as all ones
         st_reg.array <= '1;
      end else begin
         st_reg <= st_next;
      end
   end

   // ---------------------------------------------
   // Outputs
   // ---------------------------------------------
   assign link.rsp_valid = st_reg.rsp_valid;
   assign link.rsp_rdata = st_reg.rsp_rdata;
   assign link.ram_select = st_reg.ram_select;
endmodule

// ==== hdl/eedm_core.sv ====
/*
 * Core-side requester: turns user commands into data-space moves and
 * special-function accesses, one at a time, and returns the answer.
 * Assumes the controller answers every request on the next edge.
 */
`timescale 1ns/100ps
`include "eedm_regs.svh"
module eedm_core (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic cmd_valid,
   input wire logic cmd_sfr,
   input wire logic cmd_we,
   input wire logic [1:0] cmd_sel,
   input wire logic [10:0] cmd_addr,
   input wire logic [7:0] cmd_wdata,
   output logic cmd_ready,
   output logic done_valid,
   output logic [7:0] done_rdata,
   output logic done_ram,
   eedm_if.core link
);
   typedef struct packed {
      logic busy;
      logic xreq;
      logic sreq;
      logic we;
      logic [1:0] sel;
      logic [10:0] addr;
      logic [7:0] wdata;
      logic done_valid;
      logic [7:0] done_rdata;
      logic done_ram;
      logic ready;
   } eedm_core_s;

   eedm_core_s st_reg;
   eedm_core_s st_next;

   // ---------------------------------------------
   // One request in flight
   // ---------------------------------------------
   always_comb begin
      st_next = st_reg;
      st_next.xreq = 1'b0;
      st_next.sreq = 1'b0;
      st_next.done_valid = 1'b0;
      if (!st_reg.busy && cmd_valid) begin
         st_next.busy = 1'b1;
         st_next.xreq = !cmd_sfr;
         st_next.sreq = cmd_sfr;
         st_next.we = cmd_we;
         st_next.sel = cmd_sel;
         st_next.addr = cmd_addr;
         st_next.wdata = cmd_wdata;
      end
      if (st_reg.busy && link.rsp_valid) begin
         st_next.busy = 1'b0;
         st_next.done_valid = 1'b1;
         st_next.done_rdata = link.rsp_rdata;
         st_next.done_ram = link.ram_select;
      end
      // Ready is registered so the command side sees a clean flop output
      st_next.ready = !st_next.busy;
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         st_reg <= '0;
         st_reg.ready <= 1'b1;
      end else begin
         st_reg <= st_next;
      end
   end

   assign link.xdata_req = st_reg.xreq;
   assign link.sfr_req = st_reg.sreq;
   assign link.xdata_we = st_reg.we;
   assign link.sfr_we = st_reg.we;
   assign link.sfr_sel = eedm_pkg::eedm_sfr_e'(st_reg.sel);
   assign link.xdata_addr = st_reg.addr;
   assign link.xdata_wdata = st_reg.wdata;
   assign link.sfr_wdata = st_reg.wdata;
   assign cmd_ready = st_reg.ready;
   assign done_valid = st_reg.done_valid;
   assign done_rdata = st_reg.done_rdata;
   assign done_ram = st_reg.done_ram;
endmodule

// ==== dv/eedm_chk.sv ====
/* Checker for the data EEPROM link between core and controller.
   Assumes the bench instantiates it beside the interface, one clock. */
`timescale 1ns/100ps
module eedm_chk #(
   parameter int PROG_CYCLES = 8
) (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic xdata_req,
   input wire logic xdata_we,
   input wire eedm_pkg::eedm_addr_t xdata_addr,
   input wire logic sfr_req,
   input wire logic sfr_we,
   input wire eedm_pkg::eedm_sfr_e sfr_sel,
   input wire eedm_pkg::eedm_byte_t sfr_wdata,
   input wire logic rsp_valid,
   input wire eedm_pkg::eedm_byte_t rsp_rdata,
   input wire logic ram_select
);
   // ----
   // Helper state
   // ----
   logic en_reg, arm_reg, crd_reg, xrd_reg;
   logic [15:0] age_reg;
   wire logic ctrl_wr = sfr_req && sfr_we && sfr_sel == eedm_pkg::EEDM_SFR_CTRL;
   // Age saturates so a run without unlock never looks busy
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         en_reg <= 1'b0;
         arm_reg <= 1'b0;
         crd_reg <= 1'b0;
         xrd_reg <= 1'b0;
         age_reg <= 16'hffff;
      end else begin
         en_reg <= ctrl_wr ? sfr_wdata[1] : en_reg;
         arm_reg <= ctrl_wr ? sfr_wdata == 8'h52 : arm_reg;
         crd_reg <= sfr_req && !sfr_we && sfr_sel == eedm_pkg::EEDM_SFR_CTRL;
         xrd_reg <= xdata_req && !xdata_we && xdata_addr <= 11'h3ff && en_reg;
         if (ctrl_wr && arm_reg && sfr_wdata == 8'ha2) begin
            age_reg <= 16'h0000;
         end else if (age_reg != 16'hffff) begin
            age_reg <= age_reg + 16'h0001;
         end
      end
   end
   // ----
   // Properties
   // ----
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   AST_RSP_NEXT: assert property ((xdata_req || sfr_req) |=> rsp_valid)
      else $error("request not answered");
   AST_RSP_CAUSE: assert property (rsp_valid |-> $past(xdata_req) || $past(sfr_req))
      else $error("answer without request");
   AST_RAM_ONLY: assert property (ram_select |-> rsp_valid)
      else $error("ram select outside answer");
   AST_RAM_MAP: assert property (xdata_req |=>
      ram_select == ($past(xdata_addr) > 11'h3ff || !$past(en_reg)))
      else $error("wrong space selected");
   AST_BUSY_CAUSE: assert property (rsp_valid && crd_reg && rsp_rdata[0] |->
      age_reg <= PROG_CYCLES + 3) else $error("busy without unlock");
   AST_BUSY_SET: assert property (rsp_valid && crd_reg && age_reg >= 2 &&
      age_reg <= PROG_CYCLES - 3 |-> rsp_rdata[0]) else $error("busy missing");
   AST_BUSY_CLEAR: assert property (rsp_valid && crd_reg && age_reg > PROG_CYCLES + 3
      |-> !rsp_rdata[0]) else $error("busy not cleared");
   AST_READ_BUSY: assert property (rsp_valid && xrd_reg && age_reg <= PROG_CYCLES - 3
      |-> rsp_rdata == 8'hff) else $error("read served while busy");
endmodule

// ==== dv/testbench.sv ====
/* Testbench: core and controller joined by the link, driven on the core's
   command side. Assumes design files and checker compiled first. */
`timescale 1ns/100ps
module testbench;
   localparam int PROG = 24;
   logic ref_clk = 1'b0;
   logic reset_n = 1'b0;
   logic cmd_valid = 1'b0, cmd_sfr = 1'b0, cmd_we = 1'b0;
   logic [1:0] cmd_sel = 2'h0;
   logic [10:0] cmd_addr = 11'h000;
   logic [7:0] cmd_wdata = 8'h00;
   logic cmd_ready, done_valid, done_ram;
   logic [7:0] done_rdata;
   int err_count = 0, checked = 0, cycles = 0;
   eedm_if eedm_if_i ();
   eedm_ctrl #(.PROG_CYCLES(PROG)) eedm_ctrl_i (.ref_clk(ref_clk), .reset_n(reset_n),
      .link(eedm_if_i));
   eedm_core eedm_core_i (.ref_clk(ref_clk), .reset_n(reset_n), .cmd_valid(cmd_valid),
      .cmd_sfr(cmd_sfr), .cmd_we(cmd_we), .cmd_sel(cmd_sel), .cmd_addr(cmd_addr),
      .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready), .done_valid(done_valid),
      .done_rdata(done_rdata), .done_ram(done_ram), .link(eedm_if_i));
   eedm_chk #(.PROG_CYCLES(PROG)) eedm_chk_i (.ref_clk(ref_clk), .reset_n(reset_n),
      .xdata_req(eedm_if_i.xdata_req), .xdata_we(eedm_if_i.xdata_we),
      .xdata_addr(eedm_if_i.xdata_addr), .sfr_req(eedm_if_i.sfr_req),
      .sfr_we(eedm_if_i.sfr_we), .sfr_sel(eedm_if_i.sfr_sel),
      .sfr_wdata(eedm_if_i.sfr_wdata), .rsp_valid(eedm_if_i.rsp_valid),
      .rsp_rdata(eedm_if_i.rsp_rdata), .ram_select(eedm_if_i.ram_select));
   initial forever #20 ref_clk = ~ref_clk;
   // ----
   // Shared tasks
   // ----
   task automatic final_report();
      $display("checks %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // About 1200 cycles expected; a hang stops at the 20000-cycle limit
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 20000) begin
         err_count++;
         final_report();
      end
   end
   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      checked++;
      if (got !== exp) begin
         err_count++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask
   // Command held until taken; done_valid stands one cycle, seen at a falling edge
   task automatic op(input logic s, w, input logic [1:0] sl, input logic [10:0] a,
      input logic [7:0] d);
      int n;
      @(negedge ref_clk);
      cmd_valid = 1'b1;
      cmd_sfr = s;
      cmd_we = w;
      cmd_sel = sl;
      cmd_addr = a;
      cmd_wdata = d;
      for (n = 0; cmd_ready !== 1'b1 && n < 50; n++) @(negedge ref_clk);
      chk("cmd_ready", 8'h01, {7'h00, cmd_ready});
      @(negedge ref_clk);
      cmd_valid = 1'b0;
      for (n = 0; done_valid !== 1'b1 && n < 50; n++) @(negedge ref_clk);
      chk("done_valid", 8'h01, {7'h00, done_valid});
   endtask
   task automatic wr(input logic [10:0] a, input logic [7:0] d);
      op(1'b0, 1'b1, 2'h0, a, d);
   endtask
   task automatic rd(input logic [10:0] a);
      op(1'b0, 1'b0, 2'h0, a, 8'h00);
   endtask
   task automatic cw(input logic [7:0] d);
      op(1'b1, 1'b1, 2'h1, 11'h000, d);
   endtask
   task automatic cr();
      op(1'b1, 1'b0, 2'h1, 11'h000, 8'h00);
   endtask
   task automatic prog();
      int n;
      cw(8'h52);
      cw(8'ha2);
      rd(11'h080);
      chk("busy_read", 8'hff, done_rdata);
      cr();
      chk("busy_set", 8'h01, {7'h00, done_rdata[0]});
      for (n = 0; done_rdata[0] !== 1'b0 && n < 20; n++) cr();
      chk("busy_clear", 8'h00, {7'h00, done_rdata[0]});
   endtask
   // ----
   // Scenarios
   // ----
   task automatic t_map();
      wr(11'h005, 8'h77);
      chk("ram_off", 8'h01, {7'h00, done_ram});
      cw(8'h02);
      cr();
      chk("enable", 8'h02, done_rdata);
      op(1'b1, 1'b1, 2'h2, 11'h000, 8'h01);
      op(1'b1, 1'b0, 2'h2, 11'h000, 8'h00);
      chk("stretch", 8'h01, done_rdata);
      rd(11'h400);
      chk("ram_high", 8'h01, {7'h00, done_ram});
      rd(11'h3ff);
      chk("ee_sel", 8'h00, {7'h00, done_ram});
      chk("ee_blank", 8'hff, done_rdata);
      $display("test map done");
   endtask
   task automatic t_page();
      for (int i = 0; i < 128; i++) wr({4'h1, 7'(i)}, 8'(i) ^ 8'h5a);
      wr(11'h280, 8'h11);
      prog();
      for (int i = 0; i < 128; i++) begin
         rd({4'h1, 7'(i)});
         chk("page", 8'(i) ^ 8'h5a, done_rdata);
      end
      rd(11'h280);
      chk("other_page", 8'hff, done_rdata);
      $display("test page done");
   endtask
   task automatic t_session();
      wr(11'h300, 8'h3c);
      wr(11'h37f, 8'hc3);
      cw(8'h52);
      cw(8'h02);
      cw(8'ha2);
      cr();
      chk("no_unlock", 8'h00, {7'h00, done_rdata[0]});
      rd(11'h300);
      chk("latched_only", 8'hff, done_rdata);
      prog();
      rd(11'h300);
      chk("prog_lo", 8'h3c, done_rdata);
      rd(11'h37f);
      chk("prog_hi", 8'hc3, done_rdata);
      rd(11'h301);
      chk("unflagged", 8'hff, done_rdata);
      rd(11'h080);
      chk("old_row", 8'h5a, done_rdata);
      $display("test session done");
   endtask
   initial begin
      repeat (8) @(posedge ref_clk);
      @(negedge ref_clk);
      reset_n = 1'b1;
      t_map();
      t_page();
      t_session();
      final_report();
   end
endmodule
